// *** rtl/bus_hold_params.svh ***
`ifndef BUS_HOLD_PARAMS_SVH
`define BUS_HOLD_PARAMS_SVH
// Half a machine cycle in input clocks (half period of the clock output)
`define MC_HALF_CYCLES 4'h2
`define MC_CNT_RESET 4'h0
// Clock output level at reset
`define MC_CLK_RESET 1'b0
`endif

// *** rtl/bus_hold_pkg.sv ***
package bus_hold_pkg;
	// Hold arbitration states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_DRAIN = 2'b01,
		ST_HOLD = 2'b10
	} hold_state_e;
	// Pin pair for a tristate output
	typedef struct packed {
		logic dout;
		logic oe;
	} pin_drive_s;
endpackage : bus_hold_pkg

// *** rtl/external_bus_hold_and_strobe.sv ***
`timescale 1ns/1ps
`include "bus_hold_params.svh"
// Overview of operation
// - A low tristate pin floats the strobe, select, acknowledge and clock output pins.
// - The I/O strobe only follows CPU I/O accesses, never DMA ones.
// - In host-port mode the strobe pin carries general I/O bit three or the timer output.
// - With the mode pin low the select pin is an input choosing the addressed subsystem.
// - With the mode pin high the select pin drives program address bit eighteen.
// - Hold acknowledge is asserted only while in hold with the bus lines released.
// - The clock output toggles at machine-cycle rate, each cycle bounded by falling edges.
// - Setting the clock output disable bit stops driving the clock output.
module external_bus_hold_and_strobe
	import bus_hold_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic emulation_tristate_pin_n_in,
	input wire logic hold_req_n_in,
	input wire logic external_io_mode_pin_in,
	input wire logic subsystem_select_in,
	input wire logic clock_output_disable_in,
	input wire logic host_port_mode_in,
	input wire logic timer_sel_in,
	input wire logic general_io_bit_three_in,
	input wire logic timer_output_in,
	input wire logic cpu_io_access_in,
	input wire logic dma_io_access_in,
	input wire logic bus_busy_in,
	input wire logic program_address_bit_eighteen_in,
	output logic io_space_strobe_n_out,
	output logic io_space_strobe_oe_out,
	output logic subsystem_select_out,
	output logic subsystem_select_oe_out,
	output logic subsystem_select_sync_out,
	output logic bus_release_ack_n_out,
	output logic bus_release_ack_oe_out,
	output logic bus_lines_release_out,
	output logic machine_cycle_clock_out,
	output logic machine_cycle_clock_oe_out
);
	// ==========================================================
	// Pin synchronisers
	logic [1:0] off_s_r, hold_s_r, xio_s_r, sel_s_r;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			off_s_r <= 2'h3;
			hold_s_r <= 2'h3;
			xio_s_r <= 2'h0;
			sel_s_r <= 2'h0;
		end else begin
			off_s_r <= {off_s_r[0], emulation_tristate_pin_n_in};
			hold_s_r <= {hold_s_r[0], hold_req_n_in};
			xio_s_r <= {xio_s_r[0], external_io_mode_pin_in};
			sel_s_r <= {sel_s_r[0], subsystem_select_in};
		end
	end
	logic off_n, hold_req, external_io_mode_pin;
	assign off_n = off_s_r[1];
	assign hold_req = ~hold_s_r[1];
	assign external_io_mode_pin = xio_s_r[1];

	// ==========================================================
	// Machine clock
	logic mc_level, mc_start;
	machine_clock_div u_div (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.mc_level_out(mc_level),
		.mc_start_out(mc_start)
	);

	// ==========================================================
	// Hold arbitration
	hold_state_e state_r, state_nxt;
	// Waiting for the bus to go idle keeps the strobe pin driven until the transfer ends; the strobe level is cut once draining starts
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: if (hold_req) state_nxt = ST_DRAIN;
			ST_DRAIN: begin
				if (!hold_req) state_nxt = ST_RUN;
				else if (!bus_busy_in) state_nxt = ST_HOLD;
			end
			ST_HOLD: if (!hold_req) state_nxt = ST_RUN;
			default: state_nxt = ST_RUN;
		endcase
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) state_r <= ST_RUN;
		else state_r <= state_nxt;
	end
	// Acknowledge and release move together in hold; release also rises while the tristate pin is low
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			bus_release_ack_n_out <= 1'b1;
			bus_release_ack_oe_out <= 1'b0;
			bus_lines_release_out <= 1'b0;
		end else begin
			bus_release_ack_n_out <= ~(state_nxt == ST_HOLD);
			bus_release_ack_oe_out <= off_n;
			bus_lines_release_out <= (state_nxt == ST_HOLD) | ~off_n;
		end
	end

	// ==========================================================
	// Strobe and select pins
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			io_space_strobe_n_out <= 1'b1;
			io_space_strobe_oe_out <= 1'b0;
			subsystem_select_out <= 1'b0;
			subsystem_select_oe_out <= 1'b0;
			subsystem_select_sync_out <= 1'b0;
		end else begin
			if (host_port_mode_in)
				io_space_strobe_n_out <= timer_sel_in ? timer_output_in : general_io_bit_three_in;
			else // DMA I/O space never reaches the pin
				io_space_strobe_n_out <= ~(cpu_io_access_in & (state_r == ST_RUN));
			// A DMA request is simply ignored here
			io_space_strobe_oe_out <= off_n & (host_port_mode_in | state_nxt != ST_HOLD);
			subsystem_select_out <= program_address_bit_eighteen_in;
			subsystem_select_oe_out <= off_n & external_io_mode_pin & (state_nxt != ST_HOLD);
			subsystem_select_sync_out <= external_io_mode_pin ? 1'b0 : sel_s_r[1];
		end
	end

	// ==========================================================
	// Clock output pin
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			machine_cycle_clock_out <= `MC_CLK_RESET;
			machine_cycle_clock_oe_out <= 1'b0;
		end else begin
			machine_cycle_clock_out <= mc_level;
			machine_cycle_clock_oe_out <= off_n & ~clock_output_disable_in;
		end
	end

	// ==========================================================
	// Checks
	tristate_all_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!off_n |=> !io_space_strobe_oe_out && !bus_release_ack_oe_out
		&& !machine_cycle_clock_oe_out && !subsystem_select_oe_out)
		else $error("pins driven while tristate low");
	dma_no_strobe_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!host_port_mode_in && !cpu_io_access_in |=> io_space_strobe_n_out)
		else $error("strobe without cpu access");
	host_strobe_mux_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		host_port_mode_in && !timer_sel_in |=> io_space_strobe_n_out == $past(general_io_bit_three_in))
		else $error("strobe pin not carrying io bit");
	select_input_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!external_io_mode_pin |=> !subsystem_select_oe_out)
		else $error("select driven in host mode");
	select_addr_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		external_io_mode_pin && off_n && state_nxt != ST_HOLD |=> subsystem_select_oe_out
		&& subsystem_select_out == $past(program_address_bit_eighteen_in))
		else $error("address bit not driven");
	ack_only_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!bus_release_ack_n_out |-> state_r == ST_HOLD && bus_lines_release_out)
		else $error("ack outside hold");
	drain_first_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_r == ST_RUN && hold_req |=> bus_release_ack_n_out)
		else $error("hold entered without drain");
	release_ack_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_r == ST_HOLD && !hold_req |=> bus_release_ack_n_out)
		else $error("ack held after request dropped");
	clk_toggle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(machine_cycle_clock_out) |=> machine_cycle_clock_out ##1 !machine_cycle_clock_out)
		else $error("clock output half period wrong");
	clk_disable_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		clock_output_disable_in |=> !machine_cycle_clock_oe_out)
		else $error("clock output driven while disabled");

	// ==========================================================
	// Further checks on the quieter paths
	// A lone DMA access must leave the strobe pin idle
	dma_ignored_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!host_port_mode_in && dma_io_access_in && !cpu_io_access_in
		|=> io_space_strobe_n_out)
		else $error("strobe pulsed by dma access");
	timer_strobe_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		host_port_mode_in && timer_sel_in
		|=> io_space_strobe_n_out == $past(timer_output_in))
		else $error("strobe pin not carrying timer output");
	host_strobe_oe_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		off_n && host_port_mode_in
		|=> io_space_strobe_oe_out)
		else $error("io bit pin not driven in host mode");
	// Select input is only passed on while the mode pin picks the host port
	select_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		external_io_mode_pin
		|=> !subsystem_select_sync_out)
		else $error("select input passed on in memory mode");
	select_follow_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!external_io_mode_pin
		|=> subsystem_select_sync_out == $past(sel_s_r[1]))
		else $error("select input not passed on in host mode");
	// Entering hold outside host-port mode must float every bus line this block owns
	hold_float_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_nxt == ST_HOLD && !host_port_mode_in
		|=> !io_space_strobe_oe_out && !subsystem_select_oe_out && bus_lines_release_out)
		else $error("bus line driven in hold");
	busy_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_r == ST_DRAIN && bus_busy_in
		|=> bus_release_ack_n_out)
		else $error("ack given during busy transfer");
	// A request withdrawn while draining returns to normal running
	drain_abort_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_r == ST_DRAIN && !hold_req
		|=> bus_release_ack_n_out && state_r == ST_RUN)
		else $error("drain not aborted after request dropped");
	clk_enable_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		off_n && !clock_output_disable_in
		|=> machine_cycle_clock_oe_out)
		else $error("clock output not driven while enabled");
	cycle_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		mc_start
		|=> !machine_cycle_clock_out && $past(machine_cycle_clock_out))
		else $error("cycle start not on falling clock edge");
	ack_float_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		off_n
		|=> bus_release_ack_oe_out)
		else $error("ack pin floated while tristate high");
endmodule : external_bus_hold_and_strobe

// *** rtl/machine_clock_div.sv ***
`timescale 1ns/1ps
`include "bus_hold_params.svh"
// Divider producing the machine-cycle clock level and cycle-start enable
module machine_clock_div
	import bus_hold_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	output logic mc_level_out,
	output logic mc_start_out
);
	logic [3:0] cnt_r;
	// Half-period counter; cycle starts when the level falls
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cnt_r <= `MC_CNT_RESET;
			mc_level_out <= `MC_CLK_RESET;
			mc_start_out <= 1'b0;
		end else if (cnt_r == `MC_HALF_CYCLES - 4'h1) begin
			cnt_r <= `MC_CNT_RESET;
			mc_level_out <= ~mc_level_out;
			mc_start_out <= mc_level_out;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			mc_start_out <= 1'b0;
		end
	end
endmodule : machine_clock_div

// *** verification/external_bus_hold_and_strobe_bench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench top
module external_bus_hold_and_strobe_bench;
	import bus_hold_pkg::*;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, off_n = 1'b1, want = 1'b0, external_io_mode_pin = 1'b1, sel = 1'b0;
	logic dis = 1'b0, hm = 1'b0, ts = 1'b0, gp = 1'b0, to = 1'b0, cpu = 1'b0, dma = 1'b0;
	logic busy = 1'b0, a18 = 1'b0, req_n, s_n, s_oe, sl, sl_oe, sl_syn, ack_n, ack_oe, rel, mc, mc_oe;
	logic s [8];
	int n_errors = 0;
	int samples_checked = 0;
	int k;
	hold_master pm_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .want_bus_in(want),
		.hold_req_n_out(req_n));
	external_bus_hold_and_strobe dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.emulation_tristate_pin_n_in(off_n), .hold_req_n_in(req_n),
		.external_io_mode_pin_in(external_io_mode_pin), .subsystem_select_in(sel), .clock_output_disable_in(dis),
		.host_port_mode_in(hm), .timer_sel_in(ts), .general_io_bit_three_in(gp),
		.timer_output_in(to), .cpu_io_access_in(cpu), .dma_io_access_in(dma), .bus_busy_in(busy),
		.program_address_bit_eighteen_in(a18), .io_space_strobe_n_out(s_n),
		.io_space_strobe_oe_out(s_oe), .subsystem_select_out(sl), .subsystem_select_oe_out(sl_oe),
		.subsystem_select_sync_out(sl_syn), .bus_release_ack_n_out(ack_n),
		.bus_release_ack_oe_out(ack_oe), .bus_lines_release_out(rel),
		.machine_cycle_clock_out(mc), .machine_cycle_clock_oe_out(mc_oe));
	initial forever #5 mclk_in = ~mclk_in;
	// ==========================================
	// Shared tasks; inputs move 1 ns after the edge so no race with sampling
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : step
	task automatic check_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Bounded wait on the acknowledge; a hang would hide a stuck arbiter
	task automatic wait_ack(input logic want_val);
		k = 0;
		while (ack_n !== want_val && k < 12) begin
			step(1);
			k++;
		end
		if (ack_n !== want_val) begin
			n_errors++;
			$display("unexpected ack wait expected %b seen %b", want_val, ack_n);
			report_and_stop();
		end
	endtask : wait_ack
	// Strobe pin level expected from mode and accesses; DMA never counts
	function automatic logic exp_strobe(logic h, logic t, logic g, logic o, logic c);
		return h ? (t ? o : g) : !c;
	endfunction : exp_strobe
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h12aa));
		step(8);
		rst_n_in = 1'b1;
		step(4);
		// Random pin mixes; first pass forces a lone DMA access
		for (int i = 0; i < 16; i++) begin
			{external_io_mode_pin, sel, a18, cpu, dma, hm, ts, gp, to} = 9'($urandom());
			if (i == 0) {cpu, dma, hm} = 3'h2;
			step(4);
			check_bit("strobe", exp_strobe(hm, ts, gp, to, cpu), s_n);
			check_bit("strobe oe", 1'b1, s_oe);
			check_bit("select oe", external_io_mode_pin, sl_oe);
			if (external_io_mode_pin) check_bit("select out", a18, sl);
			check_bit("select sync", external_io_mode_pin ? 1'b0 : sel, sl_syn);
		end
		$display("test pins done");
		// Clock output: levels stand 2 cycles, period 4
		check_bit("clock oe on", 1'b1, mc_oe);
		for (int i = 0; i < 8; i++) begin
			s[i] = mc;
			step(1);
		end
		for (int i = 2; i < 8; i++) check_bit("clock out", ~s[i-2], s[i]);
		dis = 1'b1;
		step(3);
		check_bit("clock oe", 1'b0, mc_oe);
		dis = 1'b0;
		$display("test clock done");
		// Hold while a transfer is busy, then release
		{cpu, hm, busy, want} = 4'h3;
		step(10);
		check_bit("ack during busy", 1'b1, ack_n);
		want = 1'b0;
		step(6);
		check_bit("ack after abort", 1'b1, ack_n);
		want = 1'b1;
		step(6);
		busy = 1'b0;
		wait_ack(1'b0);
		step(1);
		check_bit("bus release", 1'b1, rel);
		check_bit("ack oe", 1'b1, ack_oe);
		check_bit("strobe oe in hold", 1'b0, s_oe);
		want = 1'b0;
		wait_ack(1'b1);
		check_bit("release after drop", 1'b0, rel);
		$display("test hold done");
		// Global tristate floats all our pins
		off_n = 1'b0;
		step(4);
		check_bit("float", 1'b0, s_oe | sl_oe | ack_oe | mc_oe);
		$display("test tristate done");
		report_and_stop();
	end
endmodule : external_bus_hold_and_strobe_bench

// *** verification/hold_master.sv ***
`timescale 1ns/1ps
// ==========================================
// Outside bus master asking for the bus lines
module hold_master (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic want_bus_in,
	output logic hold_req_n_out
);
	// Request is a level; it may drop before the acknowledge, as a real master may
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			hold_req_n_out <= 1'b1;
		end else begin
			hold_req_n_out <= !want_bus_in;
		end
	end
endmodule : hold_master
